// [logic/igmp_defs.svh]
`ifndef IGMP_DEFS_SVH
`define IGMP_DEFS_SVH

// header word field positions
`define IGMP_TYPE_MSB 31
`define IGMP_TYPE_LSB 24
`define IGMP_RESP_MSB 23
`define IGMP_RESP_LSB 16
`define IGMP_CSUM_MSB 15
`define IGMP_CSUM_LSB 0
`define IGMP_HALF_MSB 31
`define IGMP_HALF_LSB 16

// type codes
`define IGMP_TYPE_QUERY 8'h11
`define IGMP_TYPE_V1_REPORT 8'h12
`define IGMP_TYPE_V2_REPORT 8'h16
`define IGMP_TYPE_V2_LEAVE 8'h17

// group address that marks a general query
`define IGMP_GENERAL_GROUP 32'h0000_0000

// ones-complement sum of a correct message
`define IGMP_CSUM_GOOD 16'hffff

// counter width and reset values
`define IGMP_CNT_W 16
`define IGMP_CNT_MAX 16'hffff
`define IGMP_CNT_RESET 16'h0000
`define IGMP_WORD_RESET 32'h0000_0000
`define IGMP_BYTE_RESET 8'h00
`define IGMP_HALF_RESET 16'h0000

`endif

// [logic/igmp_pkg.sv]
package igmp_pkg;
`include "igmp_defs.svh"

	typedef enum logic [2:0] {
		CLS_UNKNOWN = 3'h0,
		CLS_GENERAL_QUERY = 3'h1,
		CLS_GROUP_QUERY = 3'h2,
		CLS_V1_REPORT = 3'h3,
		CLS_V2_REPORT = 3'h4,
		CLS_V2_LEAVE = 3'h5
	} msg_class_t;

	// gray sequence: header -> group -> skip
	typedef enum logic [1:0] {
		ST_HDR = 2'b00,
		ST_GRP = 2'b01,
		ST_SKIP = 2'b11
	} parse_state_t;

	typedef struct packed {
		parse_state_t fsm;
		logic [7:0] msg_type;
		logic [7:0] resp_time;
		logic [15:0] checksum;
		logic [15:0] hdr_sum;
		logic [31:0] group_addr;
		msg_class_t cls;
		logic cls_valid;
		logic csum_ok;
		logic track_update;
	} parser_state_t;

	typedef struct packed {
		logic [`IGMP_CNT_W-1:0] queries;
		logic [`IGMP_CNT_W-1:0] v1_reports;
		logic [`IGMP_CNT_W-1:0] v2_reports;
		logic [`IGMP_CNT_W-1:0] v2_leaves;
	} counter_state_t;

endpackage : igmp_pkg

// [logic/igmp_class_if.sv]
`timescale 1ns/1ps
interface igmp_class_if;
	import igmp_pkg::*;
	logic valid;
	msg_class_t cls;

	modport src (output valid, output cls);
	modport sink (input valid, input cls);
endinterface : igmp_class_if

// [logic/igmp_counters.sv]
`timescale 1ns/1ps
`include "igmp_defs.svh"
module igmp_counters (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	igmp_class_if.sink cls_if,
	output logic [`IGMP_CNT_W-1:0] query_count_out,
	output logic [`IGMP_CNT_W-1:0] v1_report_count_out,
	output logic [`IGMP_CNT_W-1:0] v2_report_count_out,
	output logic [`IGMP_CNT_W-1:0] v2_leave_count_out
);
	import igmp_pkg::*;

	counter_state_t cnt_reg;
	counter_state_t cnt_next;

	// saturate so a long-running count never wraps back to a small value
	function automatic logic [`IGMP_CNT_W-1:0] sat_inc(input logic [`IGMP_CNT_W-1:0] v);
		sat_inc = (v == `IGMP_CNT_MAX) ? v : v + `IGMP_CNT_W'(1);
	endfunction : sat_inc

	always_comb begin
		cnt_next = cnt_reg;
		if (cls_if.valid) begin
			unique case (cls_if.cls)
				CLS_GENERAL_QUERY,
				CLS_GROUP_QUERY: cnt_next.queries = sat_inc(cnt_reg.queries);
				CLS_V1_REPORT: cnt_next.v1_reports = sat_inc(cnt_reg.v1_reports);
				CLS_V2_REPORT: cnt_next.v2_reports = sat_inc(cnt_reg.v2_reports);
				CLS_V2_LEAVE: cnt_next.v2_leaves = sat_inc(cnt_reg.v2_leaves);
				CLS_UNKNOWN: cnt_next = cnt_reg;
				default: cnt_next = cnt_reg;
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cnt_reg <= '{`IGMP_CNT_RESET, `IGMP_CNT_RESET, `IGMP_CNT_RESET, `IGMP_CNT_RESET};
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	assign query_count_out = cnt_reg.queries;
	assign v1_report_count_out = cnt_reg.v1_reports;
	assign v2_report_count_out = cnt_reg.v2_reports;
	assign v2_leave_count_out = cnt_reg.v2_leaves;

	property p_v1_count;
		@(posedge core_clk_in) disable iff (!nrst_in)
		(cls_if.valid && cls_if.cls == CLS_V1_REPORT && cnt_reg.v1_reports != `IGMP_CNT_MAX)
			|=> (v1_report_count_out == $past(v1_report_count_out) + `IGMP_CNT_W'(1))
			&& $stable(v2_report_count_out) && $stable(query_count_out);
	endproperty
	a_v1_count: assert property (p_v1_count) else $error("v1 report count did not step");

	property p_leave_count;
		@(posedge core_clk_in) disable iff (!nrst_in)
		(cls_if.valid && cls_if.cls == CLS_V2_LEAVE && cnt_reg.v2_leaves != `IGMP_CNT_MAX)
			|=> (v2_leave_count_out == $past(v2_leave_count_out) + `IGMP_CNT_W'(1)) && $stable(v2_report_count_out);
	endproperty
	a_leave_count: assert property (p_leave_count) else $error("leave count did not step");

	property p_unknown_no_count;
		@(posedge core_clk_in) disable iff (!nrst_in)
		(!cls_if.valid || cls_if.cls == CLS_UNKNOWN) |=> $stable(cnt_reg);
	endproperty
	a_unknown_no_count: assert property (p_unknown_no_count) else $error("count moved without a known message");

endmodule : igmp_counters

// [logic/igmp_message_classifier.sv]
`timescale 1ns/1ps
`include "igmp_defs.svh"
// Behaviour
// - the first word gives type (top octet), max response time (next octet) and checksum (low 16 bits).
// - the second word is the group address, and all zeros there marks a general query.
// - type 0x11 with group 0.0.0.0 is a general membership query.
// - type 0x11 with a non-zero group is a group-specific query.
// - type 0x16 is a version 2 report, a join of the group.
// - type 0x17 is a version 2 leave of the group.
// - type 0x12 is a version 1 report, a join of the group.
// - messages are fixed length, so words after the group word are skipped with no option parsing.
// - separate counts are kept of queries, v1 reports, v2 reports and v2 leaves.
module igmp_message_classifier (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic word_valid_in,
	input wire logic word_first_in,
	input wire logic [31:0] word_in,
	output logic class_valid_out,
	output igmp_pkg::msg_class_t class_out,
	output logic [7:0] msg_type_out,
	output logic [7:0] resp_time_out,
	output logic [15:0] checksum_out,
	output logic [31:0] group_addr_out,
	output logic checksum_ok_out,
	output logic track_update_out,
	output logic [`IGMP_CNT_W-1:0] query_count_out,
	output logic [`IGMP_CNT_W-1:0] v1_report_count_out,
	output logic [`IGMP_CNT_W-1:0] v2_report_count_out,
	output logic [`IGMP_CNT_W-1:0] v2_leave_count_out
);
	import igmp_pkg::*;

	parser_state_t st_reg;
	parser_state_t st_next;
	logic hdr_take;
	logic grp_take;
	msg_class_t grp_cls;

	igmp_class_if cls_bus ();

	// ones-complement add with end-around carry
	function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		oc_add = s[15:0] + {15'h0000, s[16]};
	endfunction : oc_add

	function automatic msg_class_t classify(input logic [7:0] t, input logic [31:0] grp);
		classify = CLS_UNKNOWN;
		if (t == `IGMP_TYPE_QUERY && grp == `IGMP_GENERAL_GROUP) begin
			classify = CLS_GENERAL_QUERY;
		end else if (t == `IGMP_TYPE_QUERY) begin
			classify = CLS_GROUP_QUERY;
		end else if (t == `IGMP_TYPE_V2_REPORT) begin
			classify = CLS_V2_REPORT;
		end else if (t == `IGMP_TYPE_V2_LEAVE) begin
			classify = CLS_V2_LEAVE;
		end else if (t == `IGMP_TYPE_V1_REPORT) begin
			classify = CLS_V1_REPORT;
		end
	endfunction : classify

	// a first-word marker restarts parsing from any state, so a truncated message cannot poison the next
	assign hdr_take = word_valid_in && word_first_in;
	assign grp_take = word_valid_in && !word_first_in && st_reg.fsm == ST_GRP;
	assign grp_cls = classify(st_reg.msg_type, word_in);

	always_comb begin
		st_next = st_reg;
		st_next.cls_valid = 1'b0;
		st_next.track_update = 1'b0;
		if (hdr_take) begin
			st_next.fsm = ST_GRP;
			st_next.msg_type = word_in[`IGMP_TYPE_MSB:`IGMP_TYPE_LSB];
			st_next.resp_time = word_in[`IGMP_RESP_MSB:`IGMP_RESP_LSB];
			st_next.checksum = word_in[`IGMP_CSUM_MSB:`IGMP_CSUM_LSB];
			st_next.hdr_sum = oc_add(word_in[`IGMP_HALF_MSB:`IGMP_HALF_LSB], word_in[`IGMP_CSUM_MSB:`IGMP_CSUM_LSB]);
		end else if (word_valid_in) begin
			unique case (st_reg.fsm)
				ST_HDR: st_next.fsm = ST_HDR;
				ST_GRP: begin
					st_next.fsm = ST_SKIP;
					st_next.group_addr = word_in;
					st_next.cls = grp_cls;
					st_next.cls_valid = 1'b1;
					st_next.track_update = (grp_cls != CLS_UNKNOWN);
					st_next.csum_ok = oc_add(oc_add(st_reg.hdr_sum, word_in[`IGMP_HALF_MSB:`IGMP_HALF_LSB]),
						word_in[`IGMP_CSUM_MSB:`IGMP_CSUM_LSB]) == `IGMP_CSUM_GOOD;
				end
				// fixed-length messages: trailing words carry nothing to parse
				ST_SKIP: st_next.fsm = ST_SKIP;
				default: st_next.fsm = ST_HDR;
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_reg <= '{ST_HDR, `IGMP_BYTE_RESET, `IGMP_BYTE_RESET, `IGMP_HALF_RESET, `IGMP_HALF_RESET,
				`IGMP_WORD_RESET, CLS_UNKNOWN, 1'b0, 1'b0, 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign cls_bus.valid = st_reg.cls_valid;
	assign cls_bus.cls = st_reg.cls;

	igmp_counters u_counters (
		.core_clk_in(core_clk_in),
		.nrst_in(nrst_in),
		.cls_if(cls_bus.sink),
		.query_count_out(query_count_out),
		.v1_report_count_out(v1_report_count_out),
		.v2_report_count_out(v2_report_count_out),
		.v2_leave_count_out(v2_leave_count_out)
	);

	assign class_valid_out = st_reg.cls_valid;
	assign class_out = st_reg.cls;
	assign msg_type_out = st_reg.msg_type;
	assign resp_time_out = st_reg.resp_time;
	assign checksum_out = st_reg.checksum;
	assign group_addr_out = st_reg.group_addr;
	assign checksum_ok_out = st_reg.csum_ok;
	assign track_update_out = st_reg.track_update;

	sequence s_hdr;
		hdr_take;
	endsequence

	sequence s_grp;
		word_valid_in && !word_first_in && st_reg.fsm == ST_GRP;
	endsequence

	property p_hdr_fields;
		@(posedge core_clk_in) disable iff (!nrst_in)
		s_hdr |=> msg_type_out == $past(word_in[31:24]) && resp_time_out == $past(word_in[23:16])
			&& checksum_out == $past(word_in[15:0]) && !class_valid_out;
	endproperty
	a_hdr_fields: assert property (p_hdr_fields) else $error("header fields not captured");

	property p_group_capture;
		@(posedge core_clk_in) disable iff (!nrst_in)
		s_hdr ##1 s_grp |=> class_valid_out && group_addr_out == $past(word_in);
	endproperty
	a_group_capture: assert property (p_group_capture) else $error("group word not captured with a class");

	property p_general_query;
		@(posedge core_clk_in) disable iff (!nrst_in)
		(class_valid_out && msg_type_out == 8'h11 && group_addr_out == 32'h0000_0000)
			|-> class_out == CLS_GENERAL_QUERY && track_update_out;
	endproperty
	a_general_query: assert property (p_general_query) else $error("general query misclassified");

	property p_group_query;
		@(posedge core_clk_in) disable iff (!nrst_in)
		(class_valid_out && msg_type_out == 8'h11 && group_addr_out != 32'h0000_0000) |-> class_out == CLS_GROUP_QUERY;
	endproperty
	a_group_query: assert property (p_group_query) else $error("group query misclassified");

	property p_v2_report;
		@(posedge core_clk_in) disable iff (!nrst_in)
		s_grp ##0 (st_reg.msg_type == 8'h16) |=> class_out == CLS_V2_REPORT && track_update_out;
	endproperty
	a_v2_report: assert property (p_v2_report) else $error("v2 report misclassified");

	property p_v2_leave;
		@(posedge core_clk_in) disable iff (!nrst_in)
		(class_valid_out && msg_type_out == 8'h17) |-> class_out == CLS_V2_LEAVE;
	endproperty
	a_v2_leave: assert property (p_v2_leave) else $error("leave misclassified");

	property p_v1_report;
		@(posedge core_clk_in) disable iff (!nrst_in)
		(class_valid_out && msg_type_out == 8'h12) |-> class_out == CLS_V1_REPORT;
	endproperty
	a_v1_report: assert property (p_v1_report) else $error("v1 report misclassified");

	property p_skip_trailer;
		@(posedge core_clk_in) disable iff (!nrst_in)
		(st_reg.fsm == ST_SKIP && word_valid_in && !word_first_in) |=> !class_valid_out && $stable(group_addr_out);
	endproperty
	a_skip_trailer: assert property (p_skip_trailer) else $error("trailing word was parsed");

	property p_unknown;
		@(posedge core_clk_in) disable iff (!nrst_in)
		(class_valid_out && !(msg_type_out inside {8'h11, 8'h12, 8'h16, 8'h17}))
			|-> class_out == CLS_UNKNOWN && !track_update_out;
	endproperty
	a_unknown: assert property (p_unknown) else $error("unknown type touched tracking");

	property p_single_pulse;
		@(posedge core_clk_in) disable iff (!nrst_in)
		class_valid_out |=> !class_valid_out;
	endproperty
	a_single_pulse: assert property (p_single_pulse) else $error("class pulse longer than one cycle");

	property p_track_pulse;
		@(posedge core_clk_in) disable iff (!nrst_in)
		track_update_out |-> class_valid_out && class_out != CLS_UNKNOWN;
	endproperty
	a_track_pulse: assert property (p_track_pulse) else $error("tracking pulse without a known class");

	property p_group_only_second;
		@(posedge core_clk_in) disable iff (!nrst_in)
		!grp_take |=> $stable(group_addr_out) && !class_valid_out;
	endproperty
	a_group_only_second: assert property (p_group_only_second) else $error("group moved off the group word");

	property p_hdr_kept;
		@(posedge core_clk_in) disable iff (!nrst_in)
		s_grp |=> $stable(msg_type_out) && $stable(resp_time_out) && $stable(checksum_out);
	endproperty
	a_hdr_kept: assert property (p_hdr_kept) else $error("header fields changed on the group word");

	property p_leave_tracked;
		@(posedge core_clk_in) disable iff (!nrst_in)
		s_grp ##0 (st_reg.msg_type == `IGMP_TYPE_V2_LEAVE) |=> class_valid_out && track_update_out;
	endproperty
	a_leave_tracked: assert property (p_leave_tracked) else $error("leave not passed to tracking");

	property p_v1_tracked;
		@(posedge core_clk_in) disable iff (!nrst_in)
		s_grp ##0 (st_reg.msg_type == `IGMP_TYPE_V1_REPORT) |=> class_out == CLS_V1_REPORT && track_update_out;
	endproperty
	a_v1_tracked: assert property (p_v1_tracked) else $error("v1 report not passed to tracking");

endmodule : igmp_message_classifier

// [verification/igmp_lan_model.sv]
`timescale 1ns/1ps
module igmp_lan_model (
	input wire logic core_clk_in,
	output logic word_valid_out,
	output logic word_first_out,
	output logic [31:0] word_out
);
	initial begin
		word_valid_out = 1'b0;
		word_first_out = 1'b0;
		word_out = 32'h0000_0000;
	end

	// sender side checksum: header half plus group halves folded, then inverted
	function automatic logic [15:0] csum_of(input logic [15:0] hdr_hi, input logic [31:0] grp);
		logic [17:0] s;
		s = 18'(hdr_hi) + 18'(grp[31:16]) + 18'(grp[15:0]);
		s = 18'(s[15:0]) + 18'(s[17:16]);
		s = 18'(s[15:0]) + 18'(s[17:16]);
		return ~s[15:0];
	endfunction : csum_of

	task automatic put(input logic v, input logic f, input logic [31:0] w);
		word_valid_out <= v;
		word_first_out <= f;
		word_out <= w;
		@(posedge core_clk_in);
	endtask : put

	// fixed two-word message, no options; extra words model trailing junk
	task automatic send_msg(input logic [7:0] typ, input logic [7:0] resp, input logic [31:0] grp,
		input int gap, input int extra, input logic bad, input logic hdr_only);
		logic [15:0] cs;
		cs = csum_of({typ, resp}, grp) ^ {15'h0000, bad};
		put(1'b1, 1'b1, {typ, resp, cs});
		if (!hdr_only) begin
			for (int i = 0; i < gap; i++) put(1'b0, 1'b0, ~{typ, resp, cs});
			put(1'b1, 1'b0, grp);
			for (int i = 0; i < extra; i++) put(1'b1, 1'b0, grp ^ 32'h5a5a_0000 ^ i);
		end
	endtask : send_msg

	// released line shows the inverse so a stale word never looks current
	task automatic idle();
		word_valid_out <= 1'b0;
		word_first_out <= 1'b0;
		word_out <= ~word_out;
	endtask : idle
endmodule : igmp_lan_model

// [verification/igmp_message_classifier_tb.sv]
`timescale 1ns/1ps
`include "igmp_defs.svh"
module igmp_message_classifier_tb;
	import igmp_pkg::*;
	logic core_clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic word_valid, word_first;
	logic [31:0] word, group_addr_out, cap_grp;
	logic class_valid_out, checksum_ok_out, track_update_out, cap_ok, cap_trk;
	msg_class_t class_out, cap_cls;
	logic [7:0] msg_type_out, resp_time_out;
	logic [15:0] checksum_out;
	logic [`IGMP_CNT_W-1:0] q_cnt, v1_cnt, v2_cnt, lv_cnt;
	int error_cnt = 0;
	int checked = 0;
	int pulses = 0;
	int exp_cnt [4] = '{0, 0, 0, 0};

	always #20 core_clk_in = ~core_clk_in;

	igmp_lan_model lan (.core_clk_in(core_clk_in), .word_valid_out(word_valid), .word_first_out(word_first),
		.word_out(word));

	igmp_message_classifier u_dut (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .word_valid_in(word_valid),
		.word_first_in(word_first), .word_in(word), .class_valid_out(class_valid_out), .class_out(class_out),
		.msg_type_out(msg_type_out), .resp_time_out(resp_time_out), .checksum_out(checksum_out),
		.group_addr_out(group_addr_out), .checksum_ok_out(checksum_ok_out), .track_update_out(track_update_out),
		.query_count_out(q_cnt), .v1_report_count_out(v1_cnt), .v2_report_count_out(v2_cnt),
		.v2_leave_count_out(lv_cnt));

	// results only stand for one cycle, so catch them at the pulse edge
	always @(posedge core_clk_in) begin
		if (class_valid_out === 1'b1) begin
			pulses++;
			cap_cls = class_out;
			cap_grp = group_addr_out;
			cap_ok = checksum_ok_out;
			cap_trk = track_update_out;
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic conclude();
		$display("counts: %0d checked, %0d mismatches", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude

	task automatic count_exp(input msg_class_t c);
		case (c)
			CLS_GENERAL_QUERY, CLS_GROUP_QUERY: exp_cnt[0]++;
			CLS_V1_REPORT: exp_cnt[1]++;
			CLS_V2_REPORT: exp_cnt[2]++;
			CLS_V2_LEAVE: exp_cnt[3]++;
			default: ;
		endcase
	endtask : count_exp

	task automatic judge(input int exp_p, input logic [7:0] typ, input logic [7:0] resp, input logic [31:0] grp,
		input logic bad, input msg_class_t ecls);
		repeat (3) @(posedge core_clk_in);
		#1;
		chk("pulses", exp_p, pulses);
		chk("class", ecls, cap_cls);
		chk("type", typ, msg_type_out);
		chk("resp", resp, resp_time_out);
		chk("csum", lan.csum_of({typ, resp}, grp) ^ {15'h0000, bad}, checksum_out);
		chk("group", grp, cap_grp);
		chk("csum_ok", !bad, cap_ok);
		chk("track", ecls != CLS_UNKNOWN, cap_trk);
		chk("queries", exp_cnt[0], q_cnt);
		chk("v1", exp_cnt[1], v1_cnt);
		chk("v2", exp_cnt[2], v2_cnt);
		chk("leaves", exp_cnt[3], lv_cnt);
	endtask : judge

	task automatic run_msg(input logic [7:0] typ, input logic [7:0] resp, input logic [31:0] grp, input int gap,
		input int extra, input logic bad, input msg_class_t ecls);
		int p0;
		@(posedge core_clk_in);
		p0 = pulses;
		lan.send_msg(typ, resp, grp, gap, extra, bad, 1'b0);
		lan.idle();
		count_exp(ecls);
		judge(p0 + 1, typ, resp, grp, bad, ecls);
	endtask : run_msg

	task automatic t_reset_vals();
		chk("class_valid", 1'b0, class_valid_out);
		chk("class", CLS_UNKNOWN, class_out);
		chk("counts_hi", 32'h0000_0000, {q_cnt, v1_cnt});
		chk("counts_lo", 32'h0000_0000, {v2_cnt, lv_cnt});
		$display("t_reset_vals done");
	endtask : t_reset_vals

	// queries go to all-hosts with a hop limit of one; neither field reaches this stream
	task automatic t_each_class();
		run_msg(8'h11, 8'h64, 32'h0000_0000, 0, 0, 1'b0, CLS_GENERAL_QUERY);
		run_msg(8'h11, 8'hff, 32'he001_0203, 1, 0, 1'b0, CLS_GROUP_QUERY);
		run_msg(8'h16, 8'h00, 32'he001_0203, 0, 0, 1'b0, CLS_V2_REPORT);
		run_msg(8'h17, 8'h00, 32'he001_0203, 0, 0, 1'b0, CLS_V2_LEAVE);
		run_msg(8'h12, 8'h00, 32'hefff_fffe, 0, 0, 1'b0, CLS_V1_REPORT);
		run_msg(8'h22, 8'h00, 32'he001_0203, 0, 0, 1'b0, CLS_UNKNOWN);
		run_msg(8'h10, 8'h00, 32'h0000_0000, 0, 0, 1'b0, CLS_UNKNOWN);
		$display("t_each_class done");
	endtask : t_each_class

	task automatic t_gap_extra_badsum();
		run_msg(8'h16, 8'h0a, 32'he000_00fb, 3, 2, 1'b1, CLS_V2_REPORT);
		$display("t_gap_extra_badsum done");
	endtask : t_gap_extra_badsum

	task automatic t_orphan_header();
		@(posedge core_clk_in);
		lan.send_msg(8'h17, 8'h00, 32'h0, 0, 0, 1'b0, 1'b1);
		lan.idle();
		run_msg(8'h12, 8'h00, 32'he002_0001, 0, 0, 1'b0, CLS_V1_REPORT);
		$display("t_orphan_header done");
	endtask : t_orphan_header

	task automatic t_back_to_back();
		int p0;
		@(posedge core_clk_in);
		p0 = pulses;
		lan.send_msg(8'h17, 8'h00, 32'he003_0001, 0, 0, 1'b0, 1'b0);
		lan.send_msg(8'h11, 8'h64, 32'h0000_0000, 0, 0, 1'b0, 1'b0);
		lan.idle();
		count_exp(CLS_V2_LEAVE);
		count_exp(CLS_GENERAL_QUERY);
		judge(p0 + 2, 8'h11, 8'h64, 32'h0000_0000, 1'b0, CLS_GENERAL_QUERY);
		$display("t_back_to_back done");
	endtask : t_back_to_back

	// nobody answers this query, so no report may be counted afterwards
	task automatic t_unanswered_query();
		int p0;
		run_msg(8'h11, 8'h64, 32'he004_0001, 0, 0, 1'b0, CLS_GROUP_QUERY);
		p0 = pulses;
		repeat (8) @(posedge core_clk_in);
		#1;
		chk("quiet_pulses", p0, pulses);
		chk("quiet_reports", {exp_cnt[1][15:0], exp_cnt[2][15:0]}, {v1_cnt, v2_cnt});
		$display("t_unanswered_query done");
	endtask : t_unanswered_query

	initial begin
		repeat (2) @(posedge core_clk_in);
		nrst_in <= 1'b1;
		@(posedge core_clk_in);
		#1;
		t_reset_vals();
		t_each_class();
		t_gap_extra_badsum();
		t_orphan_header();
		t_back_to_back();
		t_unanswered_query();
		conclude();
	end

	// the run needs under a hundred cycles; this is ample margin
	initial begin
		#(40 * 3000);
		error_cnt++;
		$display("ERROR watchdog expected done seen hang");
		conclude();
	end
endmodule : igmp_message_classifier_tb
